// File: src/gio_map.svh
`ifndef GIO_MAP_SVH
`define GIO_MAP_SVH
// ==========================================================================
// register map
`define GIO_CTRL_ADDR   8'h00
`define GIO_STAT_ADDR   8'h04
`define GIO_ADDR_LSB    2
`define GIO_CTRL_RST    32'h0000_0000
`define GIO_RSVD_ZERO   15'h0000
// ==========================================================================
// deserializer / serializer counts
`define GIO_SER_LAST    2'h3
`define GIO_SER_FIRST   2'h0
`define GIO_SER_STEP    2'h1
`define GIO_BIT_FIRST   0
`define GIO_BIT_SECOND  1
`define GIO_BIT_LAST    3
`endif

// File: src/gio_pkg.sv
package gio_pkg;
    // ======================================================================
    // pin modes
    typedef enum logic [1:0] {
        GIO_MODE_INPUT  = 2'h0,
        GIO_MODE_OUTPUT = 2'h1,
        GIO_MODE_BIDIR  = 2'h2,
        GIO_MODE_CLKOUT = 2'h3
    } gio_mode_e;

    // ======================================================================
    // control register layout, msb first
    typedef struct packed {
        logic [14:0] rsvd;
        logic        deser;
        logic        pull_dn;
        logic        alt_sel;
        logic        resync;
        logic        dual_edge_io_out;
        logic        dual_edge_io_in;
        logic        out_inv;
        logic        oe_edge;
        logic        oe_reg;
        logic        out_edge;
        logic        out_reg;
        logic        in_edge;
        logic        in_reg;
        logic        used;
        logic        user_mode;
        gio_mode_e   mode;
    } gio_ctrl_s;

    // status register layout
    typedef struct packed {
        logic [21:0] rsvd;
        logic        pull_dn;
        logic        pull_up;
        logic        pad_oe;
        logic        pad_out;
        logic        pad_in;
        logic        alt;
        logic [3:0]  core_in;
    } gio_stat_s;
endpackage : gio_pkg

// File: src/gio_io_cell.sv
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "gio_map.svh"
// ==========================================================================
// Overview of operation
// - input mode: receive only; optional capture on chosen edge of input clock
// - alternate path drives the alternate function straight from the pad, never registered
// - dual-edge input: rising and falling capture registers give two streams
// - output mode: transmit only; optional latch on chosen edge of output clock
// - output register value may be inverted in output and bidirectional modes
// - dual-edge output: two registers muxed onto pad, one bit per half period
// - bidirectional: input clock for receive, output clock for transmit and enable
// - bidirectional: each register has its own edge; paths registered independently
// - clock-output mode forwards the core clock tree to the pad, no data
// - during configuration the pin has weak pull-up and no drive
// - unused pin in user mode: tristate, weak pull-up, or pull-down by option
// - alternate input goes to another block, bypassing the core interface
// - drive-enable register switches pad between driving and high impedance
// - input register captures pad for core; output register holds core data for pad
// - high-speed variant has 1:4 serdes at full rate; high-voltage variant none
// - dual-edge resync presents both bits on the rising edge only
// - resync delays the falling-edge bit by half a clock period
// - deserializer: first bit on core bit zero, last on bit three
module gio_io_cell #(
    parameter bit HIGH_SPEED = 1'b1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        inclk,
    input  wire logic        outclk,
    input  wire logic        clk_tree,
    input  wire logic [3:0]  core_out,
    input  wire logic        core_oe,
    output logic [3:0]       core_in,
    output logic             alt_o,
    input  wire logic        pad_i,
    output logic             pad_o,
    output logic             pad_oe,
    output logic             pull_up_o,
    output logic             pull_down_o
);
    // ======================================================================
    // bus slave
    gio_pkg::gio_ctrl_s ctrl_r;
    gio_pkg::gio_ctrl_s ctrl_wr;
    gio_pkg::gio_stat_s stat;
    logic               wr_pend_r;
    logic [31:0]        hrdata_r;
    wire                acc      = hsel & hready & htrans[1];
    wire  [7:0]         acc_addr = {haddr[7:`GIO_ADDR_LSB], 2'h0};
    wire                hit_ctrl = acc & (acc_addr == `GIO_CTRL_ADDR);
    wire                hit_stat = acc & (acc_addr == `GIO_STAT_ADDR);

    // reserved bits always stored as zero
    assign ctrl_wr      = {`GIO_RSVD_ZERO, hwdata[16:0]};
    // forward a pending write so a read right behind it sees the new value
    wire  [31:0]        ctrl_view = wr_pend_r ? ctrl_wr : ctrl_r;
    wire  [31:0]        rd_nxt    = hit_ctrl ? ctrl_view : hit_stat ? stat : 32'h0000_0000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // address phase capture, data phase write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            hrdata_r  <= 32'h0000_0000;
            ctrl_r    <= `GIO_CTRL_RST;
        end else begin
            wr_pend_r <= hit_ctrl & hwrite;
            hrdata_r  <= (acc & !hwrite) ? rd_nxt : hrdata_r;
            if (wr_pend_r) begin
                ctrl_r <= ctrl_wr;
            end
        end
    end

    // ======================================================================
    // mode decode
    wire active   = ctrl_r.user_mode & ctrl_r.used;
    wire m_in     = ctrl_r.mode == gio_pkg::GIO_MODE_INPUT;
    wire m_out    = ctrl_r.mode == gio_pkg::GIO_MODE_OUTPUT;
    wire m_bidir  = ctrl_r.mode == gio_pkg::GIO_MODE_BIDIR;
    wire m_clkout = ctrl_r.mode == gio_pkg::GIO_MODE_CLKOUT;
    wire alt_on   = active & m_in & ctrl_r.alt_sel;
    wire rx_on    = active & (m_in | m_bidir) & !alt_on;
    wire tx_on    = active & (m_out | m_bidir);
    wire ser_on   = HIGH_SPEED & ctrl_r.deser;

    // ======================================================================
    // clock edge events, clocks sampled on hclk
    logic inclk_d_r;
    logic outclk_d_r;
    wire  in_rise   = inclk & !inclk_d_r;
    wire  in_fall   = !inclk & inclk_d_r;
    wire  out_rise  = outclk & !outclk_d_r;
    wire  out_fall  = !outclk & outclk_d_r;
    wire  in_ev     = ctrl_r.in_edge ? in_fall : in_rise;
    wire  out_ev    = ctrl_r.out_edge ? out_fall : out_rise;
    wire  oe_ev     = ctrl_r.oe_edge ? out_fall : out_rise;
    wire  rise_take = ctrl_r.dual_edge_io_in ? in_rise : in_ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inclk_d_r  <= 1'b0;
            outclk_d_r <= 1'b0;
        end else begin
            inclk_d_r  <= inclk;
            outclk_d_r <= outclk;
        end
    end

    // ======================================================================
    // receive path
    logic       cap_rise_r;
    logic       cap_fall_r;
    logic       rs_rise_r;
    logic       rs_fall_r;
    logic [3:0] sh_r;
    logic [3:0] deser_r;
    logic [1:0] dcnt_r;
    logic [3:0] core_in_r;
    wire  [3:0] sh_nxt = {pad_i, sh_r[3:1]};
    wire  [1:0] dual_edge_io_bits = ctrl_r.resync ? {rs_fall_r, rs_rise_r} : {cap_fall_r, cap_rise_r};
    wire  [3:0] core_in_nxt =
        !rx_on          ? 4'h0 :
        ser_on          ? deser_r :
        ctrl_r.dual_edge_io_in  ? {2'h0, dual_edge_io_bits} :
        ctrl_r.in_reg   ? {3'h0, cap_rise_r} :
                          {3'h0, pad_i};

    // capture registers on input clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_rise_r <= 1'b0;
            cap_fall_r <= 1'b0;
            rs_rise_r  <= 1'b0;
            rs_fall_r  <= 1'b0;
        end else begin
            if (rise_take) cap_rise_r <= pad_i;
            if (in_fall) cap_fall_r <= pad_i;
            if (in_rise) rs_rise_r <= pad_i;
            if (in_rise) rs_fall_r <= cap_fall_r;
        end
    end

    // 1:4 deserializer on rising input edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_r    <= 4'h0;
            deser_r <= 4'h0;
            dcnt_r  <= `GIO_SER_FIRST;
        end else if (ser_on & in_rise) begin
            sh_r   <= sh_nxt;
            dcnt_r <= dcnt_r + `GIO_SER_STEP;
            if (dcnt_r == `GIO_SER_LAST) deser_r <= sh_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) core_in_r <= 4'h0;
        else          core_in_r <= core_in_nxt;
    end
    assign core_in = core_in_r;

    // alternate path, straight from the pad
    assign alt_o = alt_on & pad_i;

    // ======================================================================
    // transmit path
    logic       out_rise_r;
    logic       out_fall_r;
    logic       half_r;
    logic       oe_r;
    logic [3:0] ser_word_r;
    logic       ser_bit_r;
    logic [1:0] scnt_r;
    wire        out_take  = ctrl_r.dual_edge_io_out ? out_rise : out_ev;
    wire        dual_edge_io_bit  = half_r ? out_rise_r : out_fall_r;
    wire        regd      = ctrl_r.out_reg | ctrl_r.dual_edge_io_out | ser_on;
    wire        tx_raw    = ser_on          ? ser_bit_r :
                            ctrl_r.dual_edge_io_out ? dual_edge_io_bit :
                            ctrl_r.out_reg  ? out_rise_r :
                                              core_out[`GIO_BIT_FIRST];
    wire        tx_data   = tx_raw ^ (ctrl_r.out_inv & regd);
    wire        oe_val    = ctrl_r.oe_reg ? oe_r : core_oe;

    // output and enable registers on output clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_rise_r <= 1'b0;
            out_fall_r <= 1'b0;
            half_r     <= 1'b0;
            oe_r       <= 1'b0;
        end else begin
            if (out_take) out_rise_r <= core_out[`GIO_BIT_FIRST];
            if (out_fall) out_fall_r <= core_out[`GIO_BIT_SECOND];
            if (out_rise | out_fall) half_r <= out_rise;
            if (oe_ev) oe_r <= core_oe;
        end
    end

    // 1:4 serializer, bit zero sent first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ser_word_r <= 4'h0;
            ser_bit_r  <= 1'b0;
            scnt_r     <= `GIO_SER_FIRST;
        end else if (ser_on & out_rise) begin
            scnt_r <= scnt_r + `GIO_SER_STEP;
            if (scnt_r == `GIO_SER_FIRST) begin
                ser_word_r <= core_out;
                ser_bit_r  <= core_out[`GIO_BIT_FIRST];
            end else begin
                ser_bit_r <= ser_word_r[scnt_r];
            end
        end
    end

    // ======================================================================
    // pad drive and pulls
    logic pad_o_r;
    logic pad_oe_r;
    logic pull_up_r;
    logic pull_dn_r;
    wire  pad_o_nxt  = (active & m_clkout) ? clk_tree :
                       tx_on ? tx_data : 1'b0;
    wire  pad_oe_nxt = !active ? 1'b0 :
                       m_clkout ? 1'b1 :
                       tx_on ? oe_val : 1'b0;
    wire  pu_nxt     = !ctrl_r.user_mode | (!ctrl_r.used & !ctrl_r.pull_dn);
    wire  pd_nxt     = ctrl_r.user_mode & !ctrl_r.used & ctrl_r.pull_dn;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_o_r   <= 1'b0;
            pad_oe_r  <= 1'b0;
            pull_up_r <= 1'b1;
            pull_dn_r <= 1'b0;
        end else begin
            pad_o_r   <= pad_o_nxt;
            pad_oe_r  <= pad_oe_nxt;
            pull_up_r <= pu_nxt;
            pull_dn_r <= pd_nxt;
        end
    end
    assign pad_o       = pad_o_r;
    assign pad_oe      = pad_oe_r;
    assign pull_up_o   = pull_up_r;
    assign pull_down_o = pull_dn_r;

    // status view
    assign stat = {22'h0, pull_dn_r, pull_up_r, pad_oe_r, pad_o_r, pad_i, alt_o, core_in_r};

    // ======================================================================
    // checks
    cfg_no_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_r.user_mode |=> (!pad_oe && pull_up_o && !pull_down_o))
        else $error("pin driven or not pulled up during configuration");
    unused_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_r.user_mode && !ctrl_r.used) |=> (!pad_oe && (pull_down_o == $past(ctrl_r.pull_dn))
        && (pull_up_o != $past(ctrl_r.pull_dn))))
        else $error("unused pin pull selection wrong");
    alt_direct_a: assert property (@(posedge hclk) disable iff (!hresetn)
        alt_on |-> (alt_o == pad_i) ##1 (core_in == 4'h0))
        else $error("alternate path not direct or leaks to core");
    in_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_on && ctrl_r.in_reg && !ctrl_r.dual_edge_io_in && !ser_on && in_ev && $stable(ctrl_r))
        |=> ##1 (core_in[0] == $past(pad_i, 2)))
        else $error("input register not captured on chosen edge");
    dual_edge_io_in_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_fall && ctrl_r.dual_edge_io_in) |=> (cap_fall_r == $past(pad_i)))
        else $error("falling capture missed");
    resync_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_rise && ctrl_r.dual_edge_io_in && ctrl_r.resync) |=> (rs_fall_r == $past(cap_fall_r)))
        else $error("resync falling bit not delayed");
    oe_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_on && !ctrl_r.oe_reg) |=> (pad_oe == $past(core_oe)))
        else $error("drive enable does not follow core");
    clkout_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (active && m_clkout) |=> (pad_oe && pad_o == $past(clk_tree)))
        else $error("clock not forwarded to pad");
    invert_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_on && ctrl_r.out_reg && ctrl_r.out_inv && !ctrl_r.dual_edge_io_out && !ser_on)
        |=> (pad_o == !$past(out_rise_r)))
        else $error("output inversion not applied");
endmodule : gio_io_cell

// File: verif/gio_core_model.sv
`timescale 1ns/1ns
// ====================
// fabric user logic facing the pin cell
module gio_core_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] data_i,
    input  wire logic       oe_i,
    output logic            inclk,
    output logic            outclk,
    output logic            clk_tree,
    output logic [3:0]      core_out,
    output logic            core_oe
);
    // clocks stand still until a step is asked for
    initial begin
        inclk    = 1'b0;
        outclk   = 1'b0;
        clk_tree = 1'b0;
    end

    // data and drive enable launched on the fabric clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_out <= 4'h0;
            core_oe  <= 1'b0;
        end else begin
            core_out <= data_i;
            core_oe  <= oe_i;
        end
    end

    // one level change, held long enough for the cell to see it
    task automatic step(input int which, input logic v);
        @(posedge hclk);
        case (which)
            0: inclk <= v;
            1: outclk <= v;
            default: clk_tree <= v;
        endcase
        repeat (3) @(posedge hclk);
    endtask : step
endmodule : gio_core_model

// File: verif/tb_top.sv
`timescale 1ns/1ns
// ====================
// bench for the pin cell
module tb_top;
    typedef struct { int sel; logic [31:0] exp; } gio_note_s;
    localparam logic [31:0] CTRL_A = 32'h0000_0000;
    localparam logic [31:0] STAT_A = 32'h0000_0004;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_pad = 1'b0, oe_i = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  data_i = 4'h0, core_in, core_out, a;
    logic        hreadyout, hresp, alt_o, pad_o, pad_oe, pull_up_o, pull_down_o, pad_w;
    logic        inclk, outclk, clk_tree, core_oe;
    gio_pkg::gio_ctrl_s c;
    gio_note_s   notes[$];
    int          failures = 0, n_checks = 0, seed = 32'h5de4143a;
    event        seen_ev;
    string       nm[7] = '{"hrdata", "core_in", "pad_o", "pad_oe", "pull_up_o", "pull_down_o", "alt_o"};

    // ====================
    // clock, pad wire, design and fabric model
    always #50 hclk = ~hclk;
    assign pad_w = (pad_oe === 1'b1) ? pad_o : ext_pad; // cell drives the wire while enabled
    gio_io_cell dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .inclk, .outclk, .clk_tree, .core_out, .core_oe, .core_in, .alt_o,
        .pad_i(pad_w), .pad_o, .pad_oe, .pull_up_o, .pull_down_o);
    gio_core_model fab_u (.hclk, .hresetn, .data_i, .oe_i, .inclk, .outclk, .clk_tree, .core_out, .core_oe);

    // ====================
    // comparison, notes and bus cycles
    task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic note(input int s, input logic [31:0] e);
        notes.push_back('{s, e});
        -> seen_ev;
    endtask : note
    task automatic chk(input int s, input logic [31:0] e);
        repeat (3) @(posedge hclk);
        @(negedge hclk);
        note(s, e);
        @(posedge hclk);
    endtask : chk
    task automatic bus(input logic [31:0] ad, input logic w, input logic [31:0] d, input logic [31:0] e);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= ad;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        if (!w) note(0, e);
    endtask : bus
    task automatic base(input gio_pkg::gio_mode_e m);
        c = '0;
        c.mode = m;
        c.user_mode = 1'b1;
        c.used = 1'b1;
        a = 4'($random(seed));
    endtask : base
    task automatic cfg();
        bus(CTRL_A, 1'b1, c, 32'h0);
    endtask : cfg
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // monitor: oldest note against what the outputs show
    always @(seen_ev) begin : monitor
        gio_note_s   n;
        logic [31:0] v[7];
        v = '{hrdata, {28'h0, core_in}, {31'h0, pad_o}, {31'h0, pad_oe}, {31'h0, pull_up_o},
              {31'h0, pull_down_o}, {31'h0, alt_o}};
        n = notes.pop_front();
        cmp(nm[n.sel], v[n.sel], n.exp);
    end

    // watchdog
    initial begin
        repeat (6000) @(posedge hclk);
        failures++;
        report_and_stop();
    end

    // ====================
    // scenarios
    initial begin : main
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chk(4, 32'h1);
        chk(3, 32'h0);
        bus(CTRL_A, 1'b0, 32'h0, 32'h0);
        bus(32'h8, 1'b0, 32'h0, 32'h0);
        bus(CTRL_A, 1'b1, 32'hFFFF_FFFF, 32'h0);
        bus(CTRL_A, 1'b0, 32'h0, 32'h0001_FFFF);
        base(gio_pkg::GIO_MODE_INPUT);
        c.used = 1'b0;
        cfg();
        chk(4, 32'h1);
        chk(3, 32'h0);
        c.pull_dn = 1'b1;
        cfg();
        chk(5, 32'h1);
        chk(4, 32'h0);
        bus(STAT_A, 1'b0, 32'h0, 32'h0000_0200);
        // unregistered, then registered on each edge
        base(gio_pkg::GIO_MODE_INPUT);
        cfg();
        ext_pad <= a[0];
        chk(1, {31'h0, a[0]});
        chk(3, 32'h0);
        for (int e = 0; e < 2; e++) begin
            c.in_reg = 1'b1;
            c.in_edge = e[0];
            cfg();
            fab_u.step(0, e[0]);
            ext_pad <= a[e];
            fab_u.step(0, ~e[0]);
            ext_pad <= ~a[e];
            chk(1, {31'h0, a[e]});
            fab_u.step(0, e[0]);
            chk(1, {31'h0, a[e]});
        end
        fab_u.step(0, 1'b0);
        // alternate path bypasses capture and core
        c.alt_sel = 1'b1;
        cfg();
        ext_pad <= a[1];
        chk(6, {31'h0, a[1]});
        chk(1, 32'h0);
        ext_pad <= ~a[1];
        chk(6, {31'h0, ~a[1]});
        // dual edge capture, then resync
        base(gio_pkg::GIO_MODE_INPUT);
        c.dual_edge_io_in = 1'b1;
        cfg();
        ext_pad <= a[0];
        fab_u.step(0, 1'b1);
        ext_pad <= a[1];
        fab_u.step(0, 1'b0);
        chk(1, {30'h0, a[1], a[0]});
        c.resync = 1'b1;
        cfg();
        ext_pad <= a[2];
        fab_u.step(0, 1'b1);
        ext_pad <= a[3];
        fab_u.step(0, 1'b0);
        ext_pad <= a[0];
        fab_u.step(0, 1'b1);
        ext_pad <= ~a[3];
        fab_u.step(0, 1'b0);
        chk(1, {30'h0, a[3], a[0]});
        fab_u.step(0, 1'b1);
        fab_u.step(0, 1'b0);
        // deserializer word
        base(gio_pkg::GIO_MODE_INPUT);
        c.in_reg = 1'b1;
        c.deser = 1'b1;
        cfg();
        for (int i = 0; i < 4; i++) begin
            ext_pad <= a[i];
            fab_u.step(0, 1'b1);
            fab_u.step(0, 1'b0);
        end
        chk(1, {28'h0, a});
        // registered inverted output and drive enable
        base(gio_pkg::GIO_MODE_OUTPUT);
        c.out_reg = 1'b1;
        c.out_inv = 1'b1;
        cfg();
        oe_i <= 1'b1;
        data_i <= a;
        fab_u.step(1, 1'b1);
        data_i <= ~a;
        chk(2, {31'h0, ~a[0]});
        chk(3, 32'h1);
        fab_u.step(1, 1'b0);
        chk(2, {31'h0, ~a[0]});
        oe_i <= 1'b0;
        chk(3, 32'h0);
        // dual edge launch
        base(gio_pkg::GIO_MODE_OUTPUT);
        c.dual_edge_io_out = 1'b1;
        cfg();
        oe_i <= 1'b1;
        data_i <= a;
        fab_u.step(1, 1'b1);
        chk(2, {31'h0, a[0]});
        fab_u.step(1, 1'b0);
        chk(2, {31'h0, a[1]});
        // serializer word, bit zero first
        base(gio_pkg::GIO_MODE_OUTPUT);
        c.deser = 1'b1;
        cfg();
        data_i <= a;
        for (int i = 0; i < 4; i++) begin
            fab_u.step(1, 1'b1);
            chk(2, {31'h0, a[i]});
            fab_u.step(1, 1'b0);
        end
        // data and drive enable registered on the falling edge
        base(gio_pkg::GIO_MODE_OUTPUT);
        c.out_reg = 1'b1;
        c.out_edge = 1'b1;
        c.oe_reg = 1'b1;
        c.oe_edge = 1'b1;
        cfg();
        data_i <= a;
        fab_u.step(1, 1'b1);
        fab_u.step(1, 1'b0);
        data_i <= ~a;
        oe_i <= 1'b0;
        fab_u.step(1, 1'b1);
        chk(2, {31'h0, a[0]});
        chk(3, 32'h1);
        fab_u.step(1, 1'b0);
        chk(2, {31'h0, ~a[0]});
        chk(3, 32'h0);
        // forwarded clock ignores core data
        base(gio_pkg::GIO_MODE_CLKOUT);
        cfg();
        data_i <= 4'h0;
        fab_u.step(2, 1'b1);
        chk(2, 32'h1);
        data_i <= 4'hF;
        fab_u.step(2, 1'b0);
        chk(2, 32'h0);
        // bidirectional: plain transmit, falling edge receive
        base(gio_pkg::GIO_MODE_BIDIR);
        c.in_reg = 1'b1;
        c.in_edge = 1'b1;
        cfg();
        data_i <= a;
        oe_i <= 1'b1;
        chk(2, {31'h0, a[0]});
        chk(3, 32'h1);
        oe_i <= 1'b0;
        ext_pad <= a[1];
        fab_u.step(0, 1'b1);
        fab_u.step(0, 1'b0);
        chk(1, {31'h0, a[1]});
        report_and_stop();
    end
endmodule : tb_top
